// *** rtl/power_clock_mode_control.sv ***
/*
  Power and clock mode control: instruction-cycle divider, switchback,
  crystal/ring source choice, Idle/Stop entry and wake, band-gap keep-on
  during Stop and address latch strobe suppression.
  Assumes a single 50 MHz clock standing in for the crystal/ring clock,
  status inputs synchronous to it, and a plain register port.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_clk_map.svh"

// Overview of operation
// - Source bit: 1 crystal, 0 ring; 0-to-1 only with crystal ready and amp on.
// - Ring status bit reads 1 while running from ring; read-only, resets 0.
// - Divider 01/10/11 = 4/64/1024 clocks; 10 or 11 only from 01.
// - Auto-return bit lets hardware restore divide-by-4 on switchback events.
// - Crystal-disable stops the amp; setting allowed only with ring selected.
// - Three read-only bits show power-fail, high, low level in service.
// - Crystal-ready bit reads 1 once crystal is stable; resets to 1.
// - Four read-only bits show serial port transmit and receive activity.
// - Power control bit 0 enters Idle; CPU halts, clocks keep running.
// - Idle ends on any interrupt or reset.
// - Power control bit 1 enters Stop; clocking and crystal stop, ring enable keeps its value.
// - Stop ends on external interrupt or reset; internal sources cannot wake.
// - Real-time clock interrupt also wakes from Stop.
// - Band-gap keep-on bit keeps reference alive in Stop; resets 0.
// - With reference kept on, power-fail interrupt and reset wake from Stop.
// - Band-gap keep-on bit has no effect outside Stop.
// - Ring-wake bit set: run from ring at once on Stop exit.
// - After ring wake, switch to crystal after 65,536 crystal clocks.
// - Ring status reads 1 for as long as the ring wake lasts.
// - Ring-wake bit clear: Stop exit waits on crystal, no ring.
// - Strobe suppress set: strobe pulses only on external data moves.
// - Strobe suppress resets 0; strobe then pulses every instruction cycle while running, not in Idle or crystal wake.
// - New divider or source takes effect at the next instruction-cycle boundary after write.
// - Crystal ready rises 65,536 clocks after disable cleared and startup.
// - Switchback on serviceable external irq, start bit, or transmit write.
module power_clock_mode_control #(
  parameter int XTAL_WARMUP_CLOCKS = `PCM_XTAL_WARMUP
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       powerfail_level_active,
  input  wire logic       high_level_active,
  input  wire logic       low_level_active,
  input  wire logic       port1_tx_active,
  input  wire logic       port1_rx_active,
  input  wire logic       port0_tx_active,
  input  wire logic       port0_rx_active,
  input  wire logic       crystal_osc_stable,
  input  wire logic       any_irq,
  input  wire logic       ext_irq,
  input  wire logic       rtc_irq,
  input  wire logic       early_power_warning_irq,
  input  wire logic       powerfail_reset_req,
  input  wire logic       ext_irq_serviceable,
  input  wire logic       rx_start_bit,
  input  wire logic       tx_buffer_write,
  input  wire logic       external_data_move,
  output logic            cpu_halt,
  output logic            clocks_stopped,
  output logic            crystal_amp_enable,
  output logic            ring_osc_enable,
  output logic            bandgap_enable,
  output logic            cycle_strobe,
  output logic            addr_latch_strobe,
  output logic      [1:0] divider_in_force
);

  localparam logic [16:0] WARM_LAST = 17'(XTAL_WARMUP_CLOCKS - 1);

  pwr_clk_pkg::pcm_state_t s_q;
  pwr_clk_pkg::pcm_state_t s_d;

  // Derived conditions
  logic       wr_pc;
  logic       wr_ex;
  logic       wr_pm;
  logic       running;
  logic       stop_wake;
  logic       sb_event;
  logic       cyc_end;
  logic [9:0] div_last;
  logic [1:0] cd_wr;
  logic [7:0] status_v;

  always_comb begin
    wr_pc    = wr_stb && (addr == `PCM_OFS_POWER_CONTROL);
    wr_ex    = wr_stb && (addr == `PCM_OFS_EXT_FLAG_CLKSEL);
    wr_pm    = wr_stb && (addr == `PCM_OFS_POWER_MGMT);
    running  = (s_q.state == pwr_clk_pkg::ST_RUN) || (s_q.state == pwr_clk_pkg::ST_WAKE_RING);
    // only external or real-time clock sources, RTC wake
    // power-fail causes count only with reference kept on
    stop_wake = ext_irq || rtc_irq ||
                (s_q.bg_keep && (early_power_warning_irq || powerfail_reset_req));
    sb_event = ext_irq_serviceable || rx_start_bit || tx_buffer_write;
    unique case (s_q.cd_act)
      `PCM_CD_DIV64:   div_last = `PCM_LAST_DIV64;
      `PCM_CD_DIV1024: div_last = `PCM_LAST_DIV1024;
      default:         div_last = `PCM_LAST_DIV4;
    endcase
    cyc_end  = (s_q.div_cnt >= div_last);
    cd_wr    = {wdata[`PCM_PM_CD_HI_BIT], wdata[`PCM_PM_CD_LO_BIT]};
    status_v = 8'h00;
    status_v[`PCM_ST_PF_BIT]   = powerfail_level_active;
    status_v[`PCM_ST_HI_BIT]   = high_level_active;
    status_v[`PCM_ST_LO_BIT]   = low_level_active;
    status_v[`PCM_ST_CRYSTAL_READY_BIT] = s_q.crystal_ready;
    status_v[`PCM_ST_TX1_BIT]  = port1_tx_active;
    status_v[`PCM_ST_RX1_BIT]  = port1_rx_active;
    status_v[`PCM_ST_TX0_BIT]  = port0_tx_active;
    status_v[`PCM_ST_RX0_BIT]  = port0_rx_active;
  end

  always_comb begin
    s_d = s_q;
    s_d.cyc_strobe = 1'b0;
    s_d.ale        = 1'b0;

    // Divider counter runs unless Stop has frozen all clocking
    if ((s_q.state == pwr_clk_pkg::ST_STOP) || cyc_end) begin
      s_d.div_cnt = 10'h000;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 10'h001;
    end
    if (cyc_end && (s_q.state != pwr_clk_pkg::ST_STOP)) begin
      s_d.cyc_strobe = 1'b1;
      // selections land at the cycle boundary
      s_d.cd_act = s_q.cd;
      if (s_q.state != pwr_clk_pkg::ST_WAKE_RING) begin
        s_d.src_act = s_q.src_sel;
      end
      // every running cycle by default, only external moves when suppressed
      if (running && (!s_q.strb_sup || external_data_move)) begin
        s_d.ale = 1'b1;
      end
    end

    // crystal warm-up count; amp off or stopped clears readiness
    if (s_q.crystal_disable || (s_q.state == pwr_clk_pkg::ST_STOP)) begin
      s_d.crystal_ready     = 1'b0;
      s_d.warm_cnt = 17'h00000;
    end else if (!s_q.crystal_ready && crystal_osc_stable) begin
      if (s_q.warm_cnt == WARM_LAST) begin
        s_d.crystal_ready = 1'b1;
      end else begin
        s_d.warm_cnt = s_q.warm_cnt + 17'h00001;
      end
    end

    // Register writes
    if (wr_ex) begin
      // crystal only once ready and amp running
      if (!wdata[`PCM_EX_SRC_BIT]) begin
        s_d.src_sel = 1'b0;
      end else if (s_q.crystal_ready && !s_q.crystal_disable) begin
        s_d.src_sel = 1'b1;
      end
      s_d.ring_wake = wdata[`PCM_EX_RWS_BIT];
      s_d.bg_keep   = wdata[`PCM_EX_BG_BIT];
    end
    if (wr_pm) begin
      // reduced rates only from divide-by-4; reserved code ignored
      if (cd_wr == `PCM_CD_DIV4) begin
        s_d.cd = cd_wr;
      end else if ((cd_wr != `PCM_CD_RESERVED) && (s_q.cd == `PCM_CD_DIV4)) begin
        s_d.cd = cd_wr;
      end
      s_d.auto_return_enable      = wdata[`PCM_PM_SWB_BIT];
      s_d.strb_sup = wdata[`PCM_PM_STRB_BIT];
      // amp may be stopped only with ring selected
      if (!wdata[`PCM_PM_CRYSTAL_DISABLE_BIT]) begin
        s_d.crystal_disable = 1'b0;
      end else if (!s_q.src_sel) begin
        s_d.crystal_disable = 1'b1;
      end
    end
    // switchback wins over a same-cycle software write
    if (s_q.auto_return_enable && sb_event) begin
      s_d.cd = `PCM_CD_DIV4;
    end

    // Mode sequencing
    unique case (s_q.state)
      pwr_clk_pkg::ST_RUN: begin
        // Stop takes precedence when both bits are written
        if (wr_pc && wdata[`PCM_PC_STOP_BIT]) begin
          s_d.state = pwr_clk_pkg::ST_STOP;
        end else if (wr_pc && wdata[`PCM_PC_IDLE_BIT]) begin
          // halt the CPU, clocks run on
          s_d.state = pwr_clk_pkg::ST_IDLE;
        end
      end
      pwr_clk_pkg::ST_IDLE: begin
        if (any_irq) begin
          s_d.state = pwr_clk_pkg::ST_RUN;
        end
      end
      pwr_clk_pkg::ST_STOP: begin
        if (stop_wake) begin
          if (!s_q.src_sel) begin
            s_d.state = pwr_clk_pkg::ST_RUN;
          end else if (s_q.ring_wake) begin
            s_d.state   = pwr_clk_pkg::ST_WAKE_RING;
            s_d.src_act = 1'b0;
          end else begin
            // default wake waits for the crystal
            s_d.state = pwr_clk_pkg::ST_WAKE_XTAL;
          end
        end
      end
      pwr_clk_pkg::ST_WAKE_XTAL: begin
        if (s_q.crystal_ready) begin
          s_d.state = pwr_clk_pkg::ST_RUN;
        end
      end
      pwr_clk_pkg::ST_WAKE_RING: begin
        if (wr_pc && wdata[`PCM_PC_STOP_BIT]) begin
          s_d.state = pwr_clk_pkg::ST_STOP;
        end else if (s_q.crystal_ready) begin
          // automatic return to crystal after warm-up
          s_d.state   = pwr_clk_pkg::ST_RUN;
          s_d.src_act = 1'b1;
        end
      end
      default: begin
        s_d.state = pwr_clk_pkg::ST_RUN;
      end
    endcase

    // One-cycle read data; unmapped addresses read zero
    s_d.rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        `PCM_OFS_POWER_CONTROL: begin
          s_d.rdata[`PCM_PC_IDLE_BIT] = (s_q.state == pwr_clk_pkg::ST_IDLE);
          s_d.rdata[`PCM_PC_STOP_BIT] = (s_q.state == pwr_clk_pkg::ST_STOP);
        end
        `PCM_OFS_EXT_FLAG_CLKSEL: begin
          s_d.rdata[`PCM_EX_SRC_BIT]  = s_q.src_sel;
          s_d.rdata[`PCM_EX_RING_BIT] = !s_q.src_act;
          s_d.rdata[`PCM_EX_RWS_BIT]  = s_q.ring_wake;
          s_d.rdata[`PCM_EX_BG_BIT]   = s_q.bg_keep;
        end
        `PCM_OFS_POWER_MGMT: begin
          s_d.rdata[`PCM_PM_CD_HI_BIT] = s_q.cd[1];
          s_d.rdata[`PCM_PM_CD_LO_BIT] = s_q.cd[0];
          s_d.rdata[`PCM_PM_SWB_BIT]   = s_q.auto_return_enable;
          s_d.rdata[`PCM_PM_CRYSTAL_DISABLE_BIT] = s_q.crystal_disable;
          s_d.rdata[`PCM_PM_STRB_BIT]  = s_q.strb_sup;
        end
        `PCM_OFS_SERVICE_STATUS: begin
          s_d.rdata = status_v;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // Output flops follow the next state, so they switch with it
    s_d.halt    = (s_d.state != pwr_clk_pkg::ST_RUN) &&
                  (s_d.state != pwr_clk_pkg::ST_WAKE_RING);
    s_d.amp_en  = !s_d.crystal_disable && (s_d.state != pwr_clk_pkg::ST_STOP);
    s_d.ring_en = !s_d.src_act;
    // keep-on bit only matters in Stop
    s_d.bg_en   = (s_d.state != pwr_clk_pkg::ST_STOP) || s_d.bg_keep;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q            <= '0;
      s_q.state      <= pwr_clk_pkg::ST_RUN;
      s_q.cd         <= `PCM_RST_CD;
      s_q.cd_act     <= `PCM_RST_CD;
      s_q.src_sel    <= `PCM_RST_SRC;
      s_q.src_act    <= `PCM_RST_SRC;
      s_q.crystal_ready       <= `PCM_RST_CRYSTAL_READY;
      // Amplifier and reference stay powered through reset
      s_q.amp_en     <= 1'b1;
      s_q.bg_en      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from flop fields
  assign rdata              = s_q.rdata;
  assign cpu_halt           = s_q.halt;
  assign clocks_stopped     = s_q.state[2];
  assign crystal_amp_enable = s_q.amp_en;
  assign ring_osc_enable    = s_q.ring_en;
  assign bandgap_enable     = s_q.bg_en;
  assign cycle_strobe       = s_q.cyc_strobe;
  assign addr_latch_strobe  = s_q.ale;
  assign divider_in_force   = s_q.cd_act;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_src_guard;
    wr_ex && wdata[`PCM_EX_SRC_BIT] && !s_q.src_sel && (!s_q.crystal_ready || s_q.crystal_disable)
      |=> !s_q.src_sel;
  endproperty
  a_src_guard: assert property (p_src_guard) else $error("source set while crystal unready");

  property p_cd_guard;
    wr_pm && (cd_wr[1]) && (s_q.cd != `PCM_CD_DIV4) && !(s_q.auto_return_enable && sb_event)
      |=> $stable(s_q.cd);
  endproperty
  a_cd_guard: assert property (p_cd_guard) else $error("divider jumped between slow rates");

  property p_switchback;
    s_q.auto_return_enable && sb_event |=> (s_q.cd == `PCM_CD_DIV4);
  endproperty
  a_switchback: assert property (p_switchback) else $error("switchback did not restore 4");

  property p_crystal_disable_guard;
    wr_pm && wdata[`PCM_PM_CRYSTAL_DISABLE_BIT] && s_q.src_sel && !s_q.crystal_disable |=> !s_q.crystal_disable;
  endproperty
  a_crystal_disable_guard: assert property (p_crystal_disable_guard) else $error("crystal off while selected");

  property p_idle_exit;
    (s_q.state == pwr_clk_pkg::ST_IDLE) && any_irq |=> !cpu_halt;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

  property p_stop_hold;
    (s_q.state == pwr_clk_pkg::ST_STOP) && !stop_wake |=> clocks_stopped && !crystal_amp_enable;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without wake source");

  property p_bandgap;
    !clocks_stopped |-> bandgap_enable;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("reference off outside stop");

  property p_ring_wake;
    (s_q.state == pwr_clk_pkg::ST_STOP) && stop_wake && s_q.ring_wake && s_q.src_sel
      |=> ring_osc_enable && !cpu_halt;
  endproperty
  a_ring_wake: assert property (p_ring_wake) else $error("ring wake not immediate");

  property p_strobe_sup;
    // Strobe is launched from the previous cycle's suppress bit
    $past(s_q.strb_sup) && !$past(external_data_move) |-> !addr_latch_strobe;
  endproperty
  a_strobe_sup: assert property (p_strobe_sup) else $error("strobe while suppressed");

  property p_strobe_div4;
    !s_q.strb_sup && (s_q.cd_act == `PCM_CD_DIV4) && !cpu_halt && cycle_strobe
      |-> ##4 (cycle_strobe || clocks_stopped);
  endproperty
  a_strobe_div4: assert property (p_strobe_div4) else $error("cycle period not 4 clocks");

  property p_idle_entry;
    (s_q.state == pwr_clk_pkg::ST_RUN) && wr_pc && wdata[`PCM_PC_IDLE_BIT] &&
      !wdata[`PCM_PC_STOP_BIT] |=> cpu_halt && !clocks_stopped;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_ring_return;
    (s_q.state == pwr_clk_pkg::ST_WAKE_RING) && s_q.crystal_ready && !(wr_pc && wdata[`PCM_PC_STOP_BIT])
      |=> !ring_osc_enable && !cpu_halt;
  endproperty
  a_ring_return: assert property (p_ring_return) else $error("no crystal return");

endmodule
`default_nettype wire

// *** rtl/pwr_clk_map.svh ***
/*
  Register offsets, field positions, reset values and cycle counts of the
  power and clock mode control block.
  Assumes it is included by bare name wherever these figures are needed.
*/
`ifndef PWR_CLK_MAP_SVH
`define PWR_CLK_MAP_SVH

`define PCM_OFS_POWER_CONTROL   8'h87
`define PCM_OFS_EXT_FLAG_CLKSEL 8'h91
`define PCM_OFS_POWER_MGMT      8'hc4
`define PCM_OFS_SERVICE_STATUS  8'hc5

// power_control fields
`define PCM_PC_IDLE_BIT   0
`define PCM_PC_STOP_BIT   1

// ext_flag_clock_select fields
`define PCM_EX_SRC_BIT    3
`define PCM_EX_RING_BIT   2
`define PCM_EX_RWS_BIT    1
`define PCM_EX_BG_BIT     0

// power_management fields
`define PCM_PM_CD_HI_BIT  7
`define PCM_PM_CD_LO_BIT  6
`define PCM_PM_SWB_BIT    5
`define PCM_PM_CRYSTAL_DISABLE_BIT  3
`define PCM_PM_STRB_BIT   2

// service_activity_status fields
`define PCM_ST_PF_BIT     7
`define PCM_ST_HI_BIT     6
`define PCM_ST_LO_BIT     5
`define PCM_ST_CRYSTAL_READY_BIT   4
`define PCM_ST_TX1_BIT    3
`define PCM_ST_RX1_BIT    2
`define PCM_ST_TX0_BIT    1
`define PCM_ST_RX0_BIT    0

// Divider codes and reset values
`define PCM_CD_DIV4       2'h1
`define PCM_CD_DIV64      2'h2
`define PCM_CD_DIV1024    2'h3
`define PCM_CD_RESERVED   2'h0
`define PCM_RST_CD        2'h1
`define PCM_RST_SRC       1'h1
`define PCM_RST_CRYSTAL_READY      1'h1

// Last count of each instruction cycle, in clocks
`define PCM_LAST_DIV4     10'h003
`define PCM_LAST_DIV64    10'h03f
`define PCM_LAST_DIV1024  10'h3ff

// Crystal warm-up, in crystal clocks
`define PCM_XTAL_WARMUP   65536

`endif

// *** rtl/pwr_clk_pkg.sv ***
/*
  Types of the power and clock mode control block: operating states and
  the packed state record.
  Assumes pwr_clk_map.svh carries all numeric figures.
*/
package pwr_clk_pkg;

  typedef enum logic [4:0] {
    ST_RUN       = 5'b00001,
    ST_IDLE      = 5'b00010,
    ST_STOP      = 5'b00100,
    ST_WAKE_XTAL = 5'b01000,
    ST_WAKE_RING = 5'b10000
  } op_state_t;

  typedef struct packed {
    op_state_t   state;
    logic [1:0]  cd;          // divider field as written
    logic [1:0]  cd_act;      // divider in force
    logic        src_sel;     // 1 crystal, 0 ring
    logic        src_act;     // source in force, 1 crystal
    logic        auto_return_enable;
    logic        crystal_disable;
    logic        strb_sup;
    logic        ring_wake;
    logic        bg_keep;
    logic        crystal_ready;
    logic [16:0] warm_cnt;
    logic [9:0]  div_cnt;
    logic        cyc_strobe;
    logic        ale;
    logic        halt;        // CPU held, registered output
    logic        amp_en;      // crystal amplifier on
    logic        ring_en;     // ring is the source in force
    logic        bg_en;       // reference powered
    logic [7:0]  rdata;
  } pcm_state_t;

endpackage

// *** verif/tb_top.sv ***
/*
  Self-checking bench for the power and clock mode control block.
  Assumes the block's register port, a 50 MHz clock and a short
  crystal warm-up parameter so that the wake paths finish quickly.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // Warm-up shortened so Stop wakes stay short
  localparam int XW = 16;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [7:0] stat_in = 8'h00;
  logic [7:0] ev = 8'h00;
  logic       xmove = 1'b0;
  logic       xstable = 1'b1;
  logic [7:0] rdata;
  logic       cpu_halt;
  logic       clocks_stopped;
  logic       crystal_amp_enable;
  logic       ring_osc_enable;
  logic       bandgap_enable;
  logic       cycle_strobe;
  logic       addr_latch_strobe;
  logic [1:0] divider_in_force;
  int         failures = 0;
  int         checks_done = 0;

  always #10 clock = ~clock;

  power_clock_mode_control #(.XTAL_WARMUP_CLOCKS(XW)) i_power_clock_mode_control (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata),
    .powerfail_level_active(stat_in[7]), .high_level_active(stat_in[6]),
    .low_level_active(stat_in[5]), .port1_tx_active(stat_in[3]),
    .port1_rx_active(stat_in[2]), .port0_tx_active(stat_in[1]),
    .port0_rx_active(stat_in[0]), .crystal_osc_stable(xstable),
    .any_irq(ev[0]), .ext_irq(ev[1]), .rtc_irq(ev[2]),
    .early_power_warning_irq(ev[3]), .powerfail_reset_req(ev[4]),
    .ext_irq_serviceable(ev[5]), .rx_start_bit(ev[6]), .tx_buffer_write(ev[7]),
    .external_data_move(xmove), .cpu_halt(cpu_halt), .clocks_stopped(clocks_stopped),
    .crystal_amp_enable(crystal_amp_enable), .ring_osc_enable(ring_osc_enable),
    .bandgap_enable(bandgap_enable), .cycle_strobe(cycle_strobe),
    .addr_latch_strobe(addr_latch_strobe), .divider_in_force(divider_in_force)
  );

  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk(name, e, rdata);
  endtask

  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
    #1;
  endtask

  function automatic logic mon(input int k);
    case (k)
      0:       mon = cycle_strobe;
      1:       mon = cpu_halt;
      default: mon = ring_osc_enable;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure
  task automatic wait_lvl(input int k, input logic lvl, input int bound, output int n);
    n = 0;
    while (mon(k) !== lvl) begin
      if (n >= bound) begin
        failures++;
        print_verdict();
      end
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  task automatic next_strobe;
    int n;
    @(posedge clock);
    #1;
    wait_lvl(0, 1'b1, 2100, n);
  endtask

  task automatic measure(input int e);
    int n;
    next_strobe();
    @(posedge clock);
    #1;
    wait_lvl(0, 1'b1, 2100, n);
    chk("cycle_period", e, n + 1);
  endtask

  task automatic count_pulses(input int cyc, output int ns, output int na);
    ns = 0;
    na = 0;
    repeat (cyc) begin
      @(posedge clock);
      #1;
      ns += (cycle_strobe === 1'b1);
      na += (addr_latch_strobe === 1'b1);
    end
  endtask

  task automatic reset_case;
    chk("div_force_rst", 2'h1, divider_in_force);
    chk("ring_osc_rst", 1'b0, ring_osc_enable);
    rd(8'hc4, 8'h40, "pm_rst");
    rd(8'h91, 8'h08, "ex_rst");
    rd(8'hc5, 8'h10, "st_rst");
    rd(8'h87, 8'h00, "pc_rst");
    rd(8'h55, 8'h00, "unmapped");
    wr(8'hc5, 8'hff);
    rd(8'hc5, 8'h10, "st_ro");
    wr(8'h91, 8'h0c);
    rd(8'h91, 8'h08, "ring_status_ro");
  endtask

  task automatic status_case;
    logic [7:0] pats [2] = '{8'ha5, 8'h4a};
    foreach (pats[i]) begin
      @(posedge clock);
      stat_in <= pats[i];
      rd(8'hc5, (pats[i] & 8'hef) | 8'h10, "st_live");
    end
    @(posedge clock);
    stat_in <= 8'h00;
  endtask

  task automatic div_case;
    measure(4);
    wr(8'hc4, 8'h80);
    next_strobe();
    chk("div_force_64", 2'h2, divider_in_force);
    measure(64);
    wr(8'hc4, 8'hc0);
    rd(8'hc4, 8'h80, "div_64_to_1024");
    wr(8'hc4, 8'h00);
    rd(8'hc4, 8'h80, "div_reserved");
    wr(8'hc4, 8'h40);
    next_strobe();
    chk("div_force_4", 2'h1, divider_in_force);
    wr(8'hc4, 8'hc0);
    next_strobe();
    chk("div_force_1024", 2'h3, divider_in_force);
    measure(1024);
    wr(8'hc4, 8'h40);
    next_strobe();
  endtask

  task automatic swb_case;
    for (int k = 5; k <= 7; k++) begin
      wr(8'hc4, 8'ha0);
      pulse(k);
      rd(8'hc4, 8'h60, "switchback");
    end
    wr(8'hc4, 8'h80);
    pulse(7);
    rd(8'hc4, 8'h80, "no_switchback");
    wr(8'hc4, 8'h40);
  endtask

  task automatic src_case;
    wr(8'hc4, 8'h48);
    rd(8'hc4, 8'h40, "crystal_disable_on_crystal");
    wr(8'h91, 8'h00);
    repeat (2) next_strobe();
    chk("ring_in_force", 1'b1, ring_osc_enable);
    rd(8'h91, 8'h04, "ring_status_on");
    wr(8'hc4, 8'h48);
    chk("amp_off", 1'b0, crystal_amp_enable);
    rd(8'hc5, 8'h00, "xtal_not_ready");
    wr(8'h91, 8'h08);
    rd(8'h91, 8'h04, "src_refused");
    wr(8'hc4, 8'h40);
    chk("amp_on", 1'b1, crystal_amp_enable);
    repeat (XW + 4) @(posedge clock);
    rd(8'hc5, 8'h10, "xtal_ready");
    wr(8'h91, 8'h08);
    repeat (2) next_strobe();
    chk("crystal_in_force", 1'b0, ring_osc_enable);
    rd(8'h91, 8'h08, "ring_status_off");
  endtask

  task automatic idle_case;
    int ns, na;
    wr(8'h87, 8'h01);
    chk("idle_halt", 1'b1, cpu_halt);
    chk("idle_clocks", 1'b0, clocks_stopped);
    count_pulses(8, ns, na);
    chk("idle_strobes", 2, ns);
    rd(8'h87, 8'h01, "pc_idle");
    pulse(0);
    chk("idle_exit", 1'b0, cpu_halt);
    wr(8'h87, 8'h01);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("idle_rst_exit", 1'b0, cpu_halt);
    rd(8'h91, 8'h08, "ex_after_rst");
  endtask

  task automatic stop_case(input logic [7:0] cfg, input int wk, input logic ring);
    int n, ns, na;
    wr(8'h91, cfg);
    wr(8'h87, 8'h02);
    chk("stopped", 1'b1, clocks_stopped);
    chk("stop_amp_off", 1'b0, crystal_amp_enable);
    chk("stop_bandgap", cfg[0], bandgap_enable);
    count_pulses(8, ns, na);
    chk("stop_strobes", 0, ns);
    pulse(0);
    chk("no_wake_internal", 1'b1, clocks_stopped);
    if (!cfg[0]) begin
      pulse(3);
      pulse(4);
      chk("no_wake_bg_off", 1'b1, clocks_stopped);
    end
    pulse(wk);
    chk("woke", 1'b0, clocks_stopped);
    chk("run_bandgap", 1'b1, bandgap_enable);
    if (ring) begin
      chk("ring_fast_run", 1'b0, cpu_halt);
      chk("ring_wake_on", 1'b1, ring_osc_enable);
      rd(8'h91, cfg | 8'h04, "ring_status_wake");
      wait_lvl(2, 1'b0, 4 * XW, n);
      chk("ring_auto_return", 1'b1, n >= XW / 2);
      rd(8'h91, cfg, "ring_status_back");
    end else begin
      chk("xtal_wake_halt", 1'b1, cpu_halt);
      chk("xtal_wake_no_ring", 1'b0, ring_osc_enable);
      wait_lvl(1, 1'b0, 4 * XW, n);
      chk("xtal_wake_len", 1'b1, n >= XW / 2);
    end
  endtask

  task automatic strobe_case;
    int ns, na;
    count_pulses(40, ns, na);
    chk("strobe_rate", 10, ns);
    chk("ale_every_cycle", ns, na);
    wr(8'hc4, 8'h44);
    count_pulses(40, ns, na);
    chk("ale_suppressed", 0, na);
    @(posedge clock);
    xmove <= 1'b1;
    count_pulses(40, ns, na);
    chk("ale_ext_move", ns, na);
    @(posedge clock);
    xmove <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1;
    reset_case();
    status_case();
    div_case();
    swb_case();
    src_case();
    idle_case();
    stop_case(8'h08, 1, 1'b0);
    stop_case(8'h09, 4, 1'b0);
    stop_case(8'h0b, 3, 1'b1);
    stop_case(8'h0a, 2, 1'b1);
    strobe_case();
    print_verdict();
  end
endmodule

`default_nettype wire
